// ===== cpu_core_pkg.sv
package cpu_core_pkg;

  // ------------------------------------------------------------
  // Register space and flag layout
  // ------------------------------------------------------------
  localparam logic [7:0] FLAGS_ADDR = 8'hf7;
  localparam int IE_BIT = 0;
  localparam int ZERO_BIT = 1;
  localparam int CARRY_BIT = 2;
  localparam int SUPER_BIT = 3;
  localparam int BANK_BIT = 4;
  localparam logic [7:0] FLAGS_SW_MASK = 8'h17;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] PCH_RESET = 8'h00;
  localparam logic [7:0] PCL_RESET = 8'h00;

  // ------------------------------------------------------------
  // Instruction length and stack steps
  // ------------------------------------------------------------
  localparam logic [15:0] INSTR_LEN = 16'h0002;
  localparam logic [7:0] STEP_PUSH = 8'h01;
  localparam logic [7:0] STEP_CALL = 8'h02;
  localparam logic [7:0] STEP_IRQ_EXIT = 8'h03;

  // ------------------------------------------------------------
  // Command types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_TRANSFER, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_ASL
  } alu_op_type;

  typedef enum logic {MODE_IMM, MODE_DIR} addr_mode_type;

  typedef enum logic [1:0] {DST_A, DST_X, DST_F, DST_SP} dest_type;

  typedef enum logic [3:0] {
    SP_NONE, SP_PUSH, SP_POP, SP_LONG_CALL, SP_CALL,
    SP_IRQ_EXIT, SP_SUB_EXIT, SP_SWAP, SP_ADD
  } stack_op_type;

  typedef struct packed {
    alu_op_type op;
    addr_mode_type mode;
    dest_type dest;
    logic reg_space;
    logic [7:0] operand;
  } instr_type;

endpackage

// ===== cpu_core_registers.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_registers (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire cpu_core_pkg::instr_type instr_i,
  input wire logic stack_valid_i,
  input wire cpu_core_pkg::stack_op_type stack_op_i,
  input wire logic [7:0] stack_arg_i,
  input wire logic branch_valid_i,
  input wire logic [15:0] branch_target_i,
  input wire logic super_mode_i,
  input wire logic [7:0] mem_data_i,
  input wire logic reg_rd_en_i,
  input wire logic [7:0] reg_rd_addr_i,
  output logic busy_o,
  output logic mem_rd_o,
  output logic mem_reg_space_o,
  output logic [7:0] mem_addr_o,
  output logic [7:0] reg_rd_data_o,
  output logic [7:0] accumulator_o,
  output logic [7:0] index_offset_o,
  output logic [7:0] stack_top_pointer_o,
  output logic [7:0] program_counter_high_o,
  output logic [7:0] program_counter_low_o,
  output logic [7:0] processor_flags_o,
  output logic master_irq_enable_o,
  output logic register_bank_select_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} state_type;

  state_type state, next_state;
  cpu_core_pkg::instr_type held, next_held, cur;
  logic [7:0] accumulator, next_accumulator;
  logic [7:0] index_offset, next_index_offset;
  logic [7:0] stack_top_pointer, next_stack_top_pointer;
  logic [15:0] pc, next_pc;
  logic [7:0] flags, next_flags;
  logic mem_rd, next_mem_rd;
  logic mem_reg_space, next_mem_reg_space;
  logic [7:0] mem_addr, next_mem_addr;
  logic [7:0] reg_rd_data, next_reg_rd_data;
  logic accept, stack_take, exec_fire;
  logic [7:0] src, second;
  logic [8:0] alu_out;

  // Result and carry out of one ALU step
  function automatic logic [8:0] alu_calc(
    input cpu_core_pkg::alu_op_type op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin
  );
    case (op)
      cpu_core_pkg::OP_TRANSFER: alu_calc = {1'b0, b};
      cpu_core_pkg::OP_ADD: alu_calc = {1'b0, a} + {1'b0, b};
      cpu_core_pkg::OP_ADC: alu_calc = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      cpu_core_pkg::OP_SUB: alu_calc = {1'b0, a} - {1'b0, b};
      cpu_core_pkg::OP_AND: alu_calc = {1'b0, a & b};
      cpu_core_pkg::OP_OR: alu_calc = {1'b0, a | b};
      cpu_core_pkg::OP_XOR: alu_calc = {1'b0, a ^ b};
      cpu_core_pkg::OP_ASL: alu_calc = {a, 1'b0};
      default: alu_calc = 9'h000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Operand routing
  // ------------------------------------------------------------
  // Immediate runs in the cycle it is taken; direct waits for the read
  always_comb begin
    accept = instr_valid_i && (state == ST_IDLE);
    stack_take = stack_valid_i && !instr_valid_i && (state == ST_IDLE);
    cur = (state == ST_EXEC) ? held : instr_i;
    exec_fire = (accept && instr_i.mode == cpu_core_pkg::MODE_IMM) ||
                (state == ST_EXEC);
    if (cur.mode == cpu_core_pkg::MODE_IMM) begin
      src = cur.operand;
    end else if (cur.reg_space && cur.operand == cpu_core_pkg::FLAGS_ADDR) begin
      src = flags;
    end else begin
      src = mem_data_i;
    end
    case (cur.dest)
      cpu_core_pkg::DST_A: second = accumulator;
      cpu_core_pkg::DST_X: second = index_offset;
      cpu_core_pkg::DST_F: second = flags;
      cpu_core_pkg::DST_SP: second = stack_top_pointer;
      default: second = accumulator;
    endcase
    alu_out = alu_calc(cur.op, second, src, flags[cpu_core_pkg::CARRY_BIT]);
  end

  // ------------------------------------------------------------
  // Sequencer and register file next values
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_held = held;
    next_accumulator = accumulator;
    next_index_offset = index_offset;
    next_stack_top_pointer = stack_top_pointer;
    next_pc = pc;
    next_flags = flags;
    next_mem_rd = 1'b0;
    next_mem_reg_space = mem_reg_space;
    next_mem_addr = mem_addr;
    next_reg_rd_data = reg_rd_data;
    case (state)
      ST_IDLE: begin
        if (accept && instr_i.mode == cpu_core_pkg::MODE_DIR) begin
          next_state = ST_FETCH;
          next_held = instr_i;
          next_mem_rd = 1'b1;
          next_mem_addr = instr_i.operand;
          next_mem_reg_space = instr_i.reg_space;
        end
      end
      ST_FETCH: next_state = ST_EXEC;
      ST_EXEC: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    // Write back the result to the chosen destination; SP takes immediate results only
    if (exec_fire) begin
      next_pc = pc + cpu_core_pkg::INSTR_LEN;
      case (cur.dest)
        cpu_core_pkg::DST_A: next_accumulator = alu_out[7:0];
        cpu_core_pkg::DST_X: next_index_offset = alu_out[7:0];
        cpu_core_pkg::DST_SP: begin
          if (cur.mode == cpu_core_pkg::MODE_IMM) begin
            next_stack_top_pointer = alu_out[7:0];
          end
        end
        cpu_core_pkg::DST_F: begin
          // Only OR immediate sets and only AND immediate clears flags
          if (cur.mode == cpu_core_pkg::MODE_IMM &&
              (cur.op == cpu_core_pkg::OP_AND ||
               cur.op == cpu_core_pkg::OP_OR)) begin
            next_flags = alu_out[7:0] &
                         cpu_core_pkg::FLAGS_SW_MASK;
          end
        end
        default: next_accumulator = accumulator;
      endcase
      // Status update for arithmetic, logic and shift into A or X
      if (cur.op != cpu_core_pkg::OP_TRANSFER &&
          (cur.dest == cpu_core_pkg::DST_A ||
           cur.dest == cpu_core_pkg::DST_X)) begin
        next_flags[cpu_core_pkg::ZERO_BIT] = (alu_out[7:0] == 8'h00);
        next_flags[cpu_core_pkg::CARRY_BIT] = alu_out[8];
      end
    end
    // Stack pointer maintenance
    if (stack_take) begin
      case (stack_op_i)
        cpu_core_pkg::SP_PUSH:
          next_stack_top_pointer = stack_top_pointer + cpu_core_pkg::STEP_PUSH;
        cpu_core_pkg::SP_POP:
          next_stack_top_pointer = stack_top_pointer - cpu_core_pkg::STEP_PUSH;
        cpu_core_pkg::SP_LONG_CALL, cpu_core_pkg::SP_CALL:
          next_stack_top_pointer = stack_top_pointer + cpu_core_pkg::STEP_CALL;
        cpu_core_pkg::SP_IRQ_EXIT:
          next_stack_top_pointer = stack_top_pointer -
                                   cpu_core_pkg::STEP_IRQ_EXIT;
        cpu_core_pkg::SP_SUB_EXIT:
          next_stack_top_pointer = stack_top_pointer - cpu_core_pkg::STEP_CALL;
        cpu_core_pkg::SP_SWAP: begin
          next_stack_top_pointer = accumulator;
          next_accumulator = stack_top_pointer;
        end
        cpu_core_pkg::SP_ADD:
          next_stack_top_pointer = stack_top_pointer + stack_arg_i;
        default: next_stack_top_pointer = stack_top_pointer;
      endcase
    end
    if (branch_valid_i && state == ST_IDLE && !exec_fire) begin
      next_pc = branch_target_i;
    end
    // Privileged bit follows the core state only; reserved bits stay zero
    next_flags[cpu_core_pkg::SUPER_BIT] = super_mode_i;
    next_flags[7:5] = 3'h0;
    if (reg_rd_en_i) begin
      next_reg_rd_data = (reg_rd_addr_i == cpu_core_pkg::FLAGS_ADDR) ?
                         flags : 8'h00;
    end
  end

  // Registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      held <= '0;
      accumulator <= cpu_core_pkg::ACC_RESET;
      index_offset <= cpu_core_pkg::INDEX_RESET;
      stack_top_pointer <= cpu_core_pkg::SP_RESET;
      pc <= {cpu_core_pkg::PCH_RESET, cpu_core_pkg::PCL_RESET};
      flags <= cpu_core_pkg::FLAGS_RESET;
      mem_rd <= 1'b0;
      mem_reg_space <= 1'b0;
      mem_addr <= 8'h00;
      reg_rd_data <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      held <= next_held;
      accumulator <= next_accumulator;
      index_offset <= next_index_offset;
      stack_top_pointer <= next_stack_top_pointer;
      pc <= next_pc;
      flags <= next_flags;
      mem_rd <= next_mem_rd;
      mem_reg_space <= next_mem_reg_space;
      mem_addr <= next_mem_addr;
      reg_rd_data <= next_reg_rd_data;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // ------------------------------------------------------------
  // Outputs, each a flip-flop
  // ------------------------------------------------------------
  assign mem_rd_o = mem_rd;
  assign mem_reg_space_o = mem_reg_space;
  assign mem_addr_o = mem_addr;
  assign reg_rd_data_o = reg_rd_data;
  assign accumulator_o = accumulator;
  assign index_offset_o = index_offset;
  assign stack_top_pointer_o = stack_top_pointer;
  assign program_counter_high_o = pc[15:8];
  assign program_counter_low_o = pc[7:0];
  assign processor_flags_o = flags;
  assign master_irq_enable_o = flags[cpu_core_pkg::IE_BIT];
  assign register_bank_select_o = flags[cpu_core_pkg::BANK_BIT];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  chk_acc_immediate: assert property (
    accept && instr_i.mode == cpu_core_pkg::MODE_IMM &&
    instr_i.dest == cpu_core_pkg::DST_A &&
    instr_i.op == cpu_core_pkg::OP_TRANSFER
    |=> accumulator_o == $past(instr_i.operand))
    else $error("accumulator missed immediate load");
  chk_direct_fetch: assert property (
    accept && instr_i.mode == cpu_core_pkg::MODE_DIR
    |=> mem_rd_o && mem_addr_o == $past(instr_i.operand) &&
        mem_reg_space_o == $past(instr_i.reg_space) ##1 !mem_rd_o)
    else $error("direct fetch request wrong");
  chk_index_direct: assert property (
    accept && instr_i.mode == cpu_core_pkg::MODE_DIR &&
    instr_i.dest == cpu_core_pkg::DST_X &&
    instr_i.op == cpu_core_pkg::OP_TRANSFER && !instr_i.reg_space
    ##2 1 |=> index_offset_o == $past(mem_data_i))
    else $error("index not loaded from fetched data");
  chk_sp_push: assert property (
    stack_take && stack_op_i == cpu_core_pkg::SP_PUSH
    |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01)
    else $error("push did not raise stack pointer");
  chk_super_follow: assert property (
    ##1 processor_flags_o[3] == $past(super_mode_i))
    else $error("privileged bit not tracking core state");
  chk_reserved_zero: assert property (
    processor_flags_o[7:5] == 3'h0)
    else $error("reserved flag bits set");
  chk_zero_flag: assert property (
    exec_fire && cur.dest == cpu_core_pkg::DST_A &&
    cur.op != cpu_core_pkg::OP_TRANSFER
    |=> processor_flags_o[1] == (accumulator_o == 8'h00))
    else $error("zero flag disagrees with result");
  chk_pc_step: assert property (
    exec_fire |=> {program_counter_high_o, program_counter_low_o} ==
                  $past({program_counter_high_o, program_counter_low_o})
                  + 16'h0002)
    else $error("program counter did not advance by two");
  chk_irq_bank: assert property (
    master_irq_enable_o == processor_flags_o[0] &&
    register_bank_select_o == processor_flags_o[4])
    else $error("enable or bank output mismatch");
  chk_flags_and: assert property (
    accept && instr_i.mode == cpu_core_pkg::MODE_IMM &&
    instr_i.dest == cpu_core_pkg::DST_F &&
    instr_i.op == cpu_core_pkg::OP_AND
    |=> (processor_flags_o & 8'h17) ==
        ($past(processor_flags_o) & $past(instr_i.operand) & 8'h17))
    else $error("flags AND result wrong");
  chk_flags_guard: assert property (
    exec_fire && cur.dest == cpu_core_pkg::DST_F &&
    !(cur.mode == cpu_core_pkg::MODE_IMM &&
      (cur.op == cpu_core_pkg::OP_AND || cur.op == cpu_core_pkg::OP_OR))
    |=> (processor_flags_o & 8'h17) == ($past(processor_flags_o) & 8'h17))
    else $error("flags changed by a refused write");

  cov_direct: cover property (accept && instr_i.mode == cpu_core_pkg::MODE_DIR);
  cov_flags_or: cover property (exec_fire && cur.dest == cpu_core_pkg::DST_F &&
                                cur.op == cpu_core_pkg::OP_OR);
  cov_carry: cover property (exec_fire && alu_out[8]);
  cov_flags_refused: cover property (exec_fire &&
    cur.dest == cpu_core_pkg::DST_F && cur.op == cpu_core_pkg::OP_XOR);

endmodule
`default_nettype wire

// ===== cpu_core_registers_addressing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_registers_addressing_bench;
  logic sys_clk_i, reset_i, instr_valid_i, stack_valid_i, branch_valid_i;
  logic super_mode_i, reg_rd_en_i;
  cpu_core_pkg::instr_type instr_i;
  cpu_core_pkg::stack_op_type stack_op_i;
  logic [7:0] stack_arg_i, mem_data_i, reg_rd_addr_i;
  logic [15:0] branch_target_i, exp_pc;
  logic busy_o, mem_rd_o, mem_reg_space_o, master_irq_enable_o;
  logic register_bank_select_o;
  logic [7:0] mem_addr_o, reg_rd_data_o, accumulator_o, index_offset_o;
  logic [7:0] stack_top_pointer_o, program_counter_high_o;
  logic [7:0] program_counter_low_o, processor_flags_o;
  int fail_count = 0;
  int comparisons = 0;

  cpu_core_registers cpu_core_registers_i (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .stack_valid_i(stack_valid_i), .stack_op_i(stack_op_i),
    .stack_arg_i(stack_arg_i), .branch_valid_i(branch_valid_i),
    .branch_target_i(branch_target_i), .super_mode_i(super_mode_i),
    .mem_data_i(mem_data_i), .reg_rd_en_i(reg_rd_en_i),
    .reg_rd_addr_i(reg_rd_addr_i), .busy_o(busy_o), .mem_rd_o(mem_rd_o),
    .mem_reg_space_o(mem_reg_space_o), .mem_addr_o(mem_addr_o),
    .reg_rd_data_o(reg_rd_data_o), .accumulator_o(accumulator_o),
    .index_offset_o(index_offset_o),
    .stack_top_pointer_o(stack_top_pointer_o),
    .program_counter_high_o(program_counter_high_o),
    .program_counter_low_o(program_counter_low_o),
    .processor_flags_o(processor_flags_o),
    .master_irq_enable_o(master_irq_enable_o),
    .register_bank_select_o(register_bank_select_o));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    summarize;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic step;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_pc;
    check(program_counter_high_o, exp_pc[15:8]);
    check(program_counter_low_o, exp_pc[7:0]);
  endtask

  task automatic summarize;
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Issues an instruction and leaves the valid strobe up for the caller
  task automatic issue(input cpu_core_pkg::alu_op_type op,
      input cpu_core_pkg::addr_mode_type m, input cpu_core_pkg::dest_type d,
      input logic rs, input logic [7:0] v);
    instr_i = '{op: op, mode: m, dest: d, reg_space: rs, operand: v};
    instr_valid_i = 1'b1;
  endtask

  // Picks the register that a destination code names
  function automatic logic [7:0] dest_reg(input cpu_core_pkg::dest_type d);
    case (d)
      cpu_core_pkg::DST_A: dest_reg = accumulator_o;
      cpu_core_pkg::DST_X: dest_reg = index_offset_o;
      cpu_core_pkg::DST_F: dest_reg = processor_flags_o;
      default: dest_reg = stack_top_pointer_o;
    endcase
  endfunction

  // One immediate instruction, result and carry/zero judged a cycle later
  task automatic imm(input cpu_core_pkg::alu_op_type op,
      input cpu_core_pkg::dest_type d, input logic [7:0] v,
      input logic [7:0] e, input logic [1:0] zc);
    issue(op, cpu_core_pkg::MODE_IMM, d, 1'b0, v);
    step;
    exp_pc = exp_pc + 16'h0002;
    check(dest_reg(d), e);
    check({6'h00, processor_flags_o[2:1]}, {6'h00, zc});
    check_pc;
  endtask

  // Direct read: data offered only in the cycle it is consumed
  task automatic dir(input cpu_core_pkg::alu_op_type op,
      input cpu_core_pkg::dest_type d, input logic rs, input logic [7:0] a,
      input logic [7:0] dat, input logic [7:0] e);
    issue(op, cpu_core_pkg::MODE_DIR, d, rs, a);
    step;
    instr_valid_i = 1'b0;
    mem_data_i = ~dat;
    check({7'h00, mem_rd_o}, 8'h01);
    check({7'h00, busy_o}, 8'h01);
    check(mem_addr_o, a);
    check({7'h00, mem_reg_space_o}, {7'h00, rs});
    step;
    mem_data_i = dat;
    check({7'h00, mem_rd_o}, 8'h00);
    step;
    mem_data_i = ~dat;
    exp_pc = exp_pc + 16'h0002;
    check(dest_reg(d), e);
    check({7'h00, busy_o}, 8'h00);
    check_pc;
  endtask

  task automatic stk(input cpu_core_pkg::stack_op_type op,
      input logic [7:0] arg, input logic [7:0] e);
    stack_op_i = op;
    stack_arg_i = arg;
    stack_valid_i = 1'b1;
    step;
    check(stack_top_pointer_o, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd_addr_i = a;
    reg_rd_en_i = 1'b1;
    step;
    check(reg_rd_data_o, e);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset;
    exp_pc = 16'h0000;
    check(processor_flags_o, 8'h02);
    check(accumulator_o, 8'h00);
    check(index_offset_o, 8'h00);
    check(stack_top_pointer_o, 8'h00);
    check_pc;
  endtask

  task automatic s_arith;
    imm(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_A, 8'h07, 8'h07, 2'b01);
    imm(cpu_core_pkg::OP_ADD, cpu_core_pkg::DST_A, 8'hfa, 8'h01, 2'b10);
    imm(cpu_core_pkg::OP_ADC, cpu_core_pkg::DST_A, 8'h01, 8'h03, 2'b00);
    imm(cpu_core_pkg::OP_SUB, cpu_core_pkg::DST_A, 8'h03, 8'h00, 2'b01);
    imm(cpu_core_pkg::OP_SUB, cpu_core_pkg::DST_A, 8'h01, 8'hff, 2'b10);
    imm(cpu_core_pkg::OP_AND, cpu_core_pkg::DST_A, 8'h80, 8'h80, 2'b00);
    imm(cpu_core_pkg::OP_ASL, cpu_core_pkg::DST_A, 8'h00, 8'h00, 2'b11);
    imm(cpu_core_pkg::OP_OR, cpu_core_pkg::DST_A, 8'h00, 8'h00, 2'b01);
    imm(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_X, 8'h08, 8'h08, 2'b01);
    imm(cpu_core_pkg::OP_XOR, cpu_core_pkg::DST_X, 8'h08, 8'h00, 2'b01);
    imm(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_SP, 8'h40, 8'h40, 2'b01);
  endtask

  task automatic s_flags;
    super_mode_i = 1'b1;
    imm(cpu_core_pkg::OP_OR, cpu_core_pkg::DST_F, 8'hff, 8'h1f, 2'b11);
    check({7'h00, master_irq_enable_o}, 8'h01);
    check({7'h00, register_bank_select_o}, 8'h01);
    imm(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_F, 8'h00, 8'h1f, 2'b11);
    imm(cpu_core_pkg::OP_ADD, cpu_core_pkg::DST_F, 8'h00, 8'h1f, 2'b11);
    imm(cpu_core_pkg::OP_XOR, cpu_core_pkg::DST_F, 8'h1f, 8'h1f, 2'b11);
    imm(cpu_core_pkg::OP_AND, cpu_core_pkg::DST_F, 8'heb, 8'h0b, 2'b01);
    check({7'h00, register_bank_select_o}, 8'h00);
    imm(cpu_core_pkg::OP_AND, cpu_core_pkg::DST_F, 8'h00, 8'h08, 2'b00);
    check({7'h00, master_irq_enable_o}, 8'h00);
    instr_valid_i = 1'b0;
    super_mode_i = 1'b0;
    step;
    check(processor_flags_o, 8'h00);
    imm(cpu_core_pkg::OP_OR, cpu_core_pkg::DST_F, 8'h13, 8'h13, 2'b01);
    instr_valid_i = 1'b0;
    step;
  endtask

  task automatic s_direct;
    dir(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_X, 1'b1, 8'hf7, 8'h5a,
        8'h13);
    dir(cpu_core_pkg::OP_ADD, cpu_core_pkg::DST_A, 1'b0, 8'h10, 8'h25,
        8'h25);
    dir(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_X, 1'b1, 8'h20, 8'h3c,
        8'h3c);
    dir(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_X, 1'b0, 8'h30, 8'h66,
        8'h66);
    rd(8'hf7, 8'h11);
    rd(8'hf6, 8'h00);
    reg_rd_en_i = 1'b0;
  endtask

  task automatic s_stack;
    stk(cpu_core_pkg::SP_PUSH, 8'h00, 8'h41);
    stk(cpu_core_pkg::SP_POP, 8'h00, 8'h40);
    stk(cpu_core_pkg::SP_LONG_CALL, 8'h00, 8'h42);
    stk(cpu_core_pkg::SP_CALL, 8'h00, 8'h44);
    stk(cpu_core_pkg::SP_IRQ_EXIT, 8'h00, 8'h41);
    stk(cpu_core_pkg::SP_SUB_EXIT, 8'h00, 8'h3f);
    stk(cpu_core_pkg::SP_ADD, 8'h11, 8'h50);
    stk(cpu_core_pkg::SP_NONE, 8'h00, 8'h50);
    stk(cpu_core_pkg::SP_SWAP, 8'h00, 8'h25);
    check(accumulator_o, 8'h50);
    stack_op_i = cpu_core_pkg::SP_PUSH;
    imm(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_A, 8'h01, 8'h01, 2'b00);
    check(stack_top_pointer_o, 8'h25);
    stack_valid_i = 1'b0;
    instr_valid_i = 1'b0;
  endtask

  task automatic s_branch;
    branch_target_i = 16'h1ffe;
    branch_valid_i = 1'b1;
    step;
    branch_valid_i = 1'b0;
    exp_pc = 16'h1ffe;
    check_pc;
    imm(cpu_core_pkg::OP_TRANSFER, cpu_core_pkg::DST_A, 8'h00, 8'h00, 2'b00);
    instr_valid_i = 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_i = 1'b1;
    {instr_valid_i, stack_valid_i, branch_valid_i} = 3'b000;
    {super_mode_i, reg_rd_en_i} = 2'b00;
    instr_i = '0;
    stack_op_i = cpu_core_pkg::SP_NONE;
    {stack_arg_i, mem_data_i, reg_rd_addr_i} = 24'h000000;
    branch_target_i = 16'h0000;
    repeat (2) step;
    reset_i = 1'b0;
    s_reset;
    s_arith;
    s_flags;
    s_direct;
    s_stack;
    s_branch;
    reset_i = 1'b1;
    step;
    reset_i = 1'b0;
    step;
    s_reset;
    summarize;
  end
endmodule
`default_nettype wire
